// *** hdl/mcafr_pkg.sv ***
package mcafr_pkg;

	// ***************************************************
	// register offsets (byte addresses)
	// ***************************************************
	localparam logic [7:0] REMAP_CONTROL_OFS = 8'h00;
	localparam logic [7:0] ABORT_STATUS_OFS = 8'h04;
	localparam logic [7:0] ABORT_ADDRESS_OFS = 8'h08;
	localparam logic [7:0] FLASH_MODE_OFS = 8'h60;
	localparam logic [7:0] LOCK_BITS_OFS = 8'h64;
	localparam logic [7:0] NVM_BITS_OFS = 8'h68;

	// ***************************************************
	// field positions
	// ***************************************************
	localparam int REMAP_TOGGLE_BIT = 0;
	localparam int UNDEF_FLAG_BIT = 0;
	localparam int MISALIGN_FLAG_BIT = 1;
	localparam int ABORT_SIZE_LSB = 8;
	localparam int ABORT_TYPE_LSB = 10;
	localparam int LAST_SRC_LSB = 16;
	localparam int SAVED_SRC_LSB = 24;
	localparam int FWS_LSB = 8;
	localparam int SECURITY_BIT = 3;

	// ***************************************************
	// reset values
	// ***************************************************
	localparam logic [31:0] STATUS_RST = 32'h0000_0000;
	localparam logic [31:0] ADDRESS_RST = 32'h0000_0000;
	localparam logic [1:0] FWS_RST = 2'h0;
	localparam logic REMAP_RST = 1'b0;

	// ***************************************************
	// access encodings
	// ***************************************************
	localparam logic [1:0] SIZE_BYTE = 2'h0;
	localparam logic [1:0] SIZE_HALF = 2'h1;
	localparam logic [1:0] SIZE_WORD = 2'h2;
	localparam logic [1:0] TYPE_DATA_READ = 2'h0;
	localparam logic [1:0] TYPE_DATA_WRITE = 2'h1;
	localparam logic [1:0] TYPE_CODE_FETCH = 2'h2;
	localparam logic [1:0] MASTER_ETH = 2'h0;
	localparam logic [1:0] MASTER_PDMA = 2'h1;
	localparam logic [1:0] MASTER_PROC = 2'h2;

	// ***************************************************
	// flash read sequencer states
	// ***************************************************
	typedef enum logic [0:0] {
		ST_IDLE,
		ST_WAIT
	} mcafr_state_t;

endpackage

// *** hdl/mcafr_top.sv ***
// Local design decision: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none

module mcafr_top #(
	parameter int FLASH_AW = 16,
	parameter int PAGE_AW = 6,
	parameter int LOCK_BITS = 16,
	parameter int NVM_BITS = 3,
	parameter bit HAS_NVM = 1'b1
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic [7:0] i_reg_addr,
	input wire logic [31:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [31:0] o_reg_rdata,
	input wire logic i_acc_valid,
	input wire logic [31:0] i_acc_addr,
	input wire logic [1:0] i_acc_size,
	input wire logic [1:0] i_acc_type,
	input wire logic [1:0] i_acc_master,
	input wire logic [31:0] i_acc_wdata,
	input wire logic i_acc_undef,
	input wire logic i_acc_flash,
	output logic o_acc_done,
	output logic [31:0] o_acc_rdata,
	output logic o_abort,
	output logic o_remap,
	output logic [FLASH_AW-1:0] o_fl_addr,
	input wire logic [31:0] i_fl_rdata,
	input wire logic [PAGE_AW-1:0] i_pbuf_idx,
	output logic [31:0] o_pbuf_data,
	output logic [LOCK_BITS-1:0] o_lock,
	output logic [NVM_BITS:0] o_nvm
);

	// ***************************************************
	// helpers
	// ***************************************************
	// cycles an array read takes; seq is a fetch served from the prefetch
	function automatic logic [1:0] cost_f(input logic [1:0] flash_wait_states, input logic seq);
		logic [1:0] c;
		c = 2'h1;
		if (seq) begin
			c = (flash_wait_states >= 2'h2) ? flash_wait_states : 2'h1;
		end else if (flash_wait_states == 2'h1) begin
			c = 2'h2;
		end else if (flash_wait_states != 2'h0) begin
			c = flash_wait_states;
		end
		return c;
	endfunction

	function automatic logic [2:0] onehot_f(input logic [1:0] m);
		logic [2:0] v;
		v = 3'h0;
		if (m == mcafr_pkg::MASTER_ETH) v[0] = 1'b1;
		if (m == mcafr_pkg::MASTER_PDMA) v[1] = 1'b1;
		if (m == mcafr_pkg::MASTER_PROC) v[2] = 1'b1;
		return v;
	endfunction

	// ***************************************************
	// register state
	// ***************************************************
	logic remap_ff;
	logic undef_ff;
	logic misalign_ff;
	logic [1:0] abort_size_ff;
	logic [1:0] abort_type_ff;
	logic [2:0] last_src_ff;
	logic [2:0] saved_src_ff;
	logic last_unread_ff;
	logic [31:0] abort_addr_ff;
	logic [1:0] fws_ff;
	logic [LOCK_BITS-1:0] lock_ff;
	logic [NVM_BITS:0] nvm_ff;
	logic [31:0] reg_rdata_ff;

	// ***************************************************
	// access sequencer state
	// ***************************************************
	mcafr_pkg::mcafr_state_t state_ff;
	logic acc_done_ff;
	logic [31:0] acc_rdata_ff;
	logic abort_ff;
	logic [1:0] cnt_ff;
	logic ld_buf_ff;
	logic [FLASH_AW-1:0] fl_addr_ff;
	logic [FLASH_AW-1:0] buf_tag_ff;
	logic [31:0] buf_data_ff;
	logic buf_vld_ff;
	logic [FLASH_AW-1:0] pf_tag_ff;
	logic pf_pend_ff;
	logic [31:0] pbuf_mem [2**PAGE_AW];
	logic [31:0] pbuf_data_ff;

	// ***************************************************
	// request decode
	// ***************************************************
	logic take;
	logic is_fetch;
	logic misaligned;
	logic abort_now;
	logic [FLASH_AW-1:0] word_idx;
	logic buf_hit;
	logic pf_hit;
	logic [1:0] cost;
	logic sts_rd;
	logic rd_take;

	// a held request is not retaken in the cycle its done pulse shows
	assign take = i_ce && i_acc_valid && !acc_done_ff && (state_ff == mcafr_pkg::ST_IDLE);
	assign is_fetch = (i_acc_type == mcafr_pkg::TYPE_CODE_FETCH);
	// processor fetches skip the alignment check
	assign misaligned = !(is_fetch && i_acc_master == mcafr_pkg::MASTER_PROC) &&
		(((i_acc_size == mcafr_pkg::SIZE_WORD) && (i_acc_addr[1:0] != 2'h0)) ||
		((i_acc_size == mcafr_pkg::SIZE_HALF) && i_acc_addr[0]));
	assign abort_now = take && (misaligned || i_acc_undef);
	// flash repeats through its area: upper bits are dropped
	assign word_idx = i_acc_addr[FLASH_AW+1:2];
	assign buf_hit = buf_vld_ff && (buf_tag_ff == word_idx);
	assign pf_hit = pf_pend_ff && (pf_tag_ff == word_idx);
	assign cost = cost_f(fws_ff, is_fetch && pf_hit);
	assign sts_rd = i_ce && i_reg_rd && (i_reg_addr == mcafr_pkg::ABORT_STATUS_OFS);
	// reads that go to the array in the take cycle; buffer hits stay off it
	assign rd_take = take && !abort_now && i_acc_flash && (i_acc_type != mcafr_pkg::TYPE_DATA_WRITE) &&
		!(is_fetch && buf_hit);

	// ***************************************************
	// remap toggle
	// ***************************************************
	// writing zero leaves the mapping alone
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			remap_ff <= mcafr_pkg::REMAP_RST;
		end else if (i_ce && i_reg_wr && (i_reg_addr == mcafr_pkg::REMAP_CONTROL_OFS) &&
			i_reg_wdata[mcafr_pkg::REMAP_TOGGLE_BIT]) begin
			remap_ff <= !remap_ff;
		end
	end

	// ***************************************************
	// abort capture
	// ***************************************************
	// every new abort overwrites the previous description
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			undef_ff <= 1'b0;
			misalign_ff <= 1'b0;
			abort_size_ff <= 2'h0;
			abort_type_ff <= 2'h0;
			last_src_ff <= 3'h0;
			abort_addr_ff <= mcafr_pkg::ADDRESS_RST;
		end else if (abort_now) begin
			undef_ff <= i_acc_undef;
			misalign_ff <= misaligned;
			abort_size_ff <= i_acc_size;
			abort_type_ff <= i_acc_type;
			last_src_ff <= onehot_f(i_acc_master);
			abort_addr_ff <= i_acc_addr;
		end
	end

	// older unread aborts move into the saved bits; a new abort beats the read clear
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			saved_src_ff <= 3'h0;
			last_unread_ff <= 1'b0;
		end else if (abort_now) begin
			saved_src_ff <= (sts_rd ? 3'h0 : saved_src_ff) |
				(last_unread_ff && !sts_rd ? last_src_ff : 3'h0);
			last_unread_ff <= 1'b1;
		end else if (sts_rd) begin
			saved_src_ff <= 3'h0;
			last_unread_ff <= 1'b0;
		end
	end

	// ***************************************************
	// configuration registers
	// ***************************************************
	// wait states must suit the clock before flash data is trusted
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			fws_ff <= mcafr_pkg::FWS_RST;
			lock_ff <= '0;
			nvm_ff <= '0;
		end else if (i_ce && i_reg_wr) begin
			if (i_reg_addr == mcafr_pkg::FLASH_MODE_OFS) begin
				fws_ff <= i_reg_wdata[mcafr_pkg::FWS_LSB +: 2];
			end
			if (i_reg_addr == mcafr_pkg::LOCK_BITS_OFS) begin
				lock_ff <= i_reg_wdata[LOCK_BITS-1:0];
			end
			// a second controller carries no nonvolatile or security bits
			if (HAS_NVM && (i_reg_addr == mcafr_pkg::NVM_BITS_OFS)) begin
				nvm_ff <= i_reg_wdata[NVM_BITS:0];
			end
		end
	end

	// ***************************************************
	// register read port
	// ***************************************************
	// data stands one cycle after the strobe, zero elsewhere
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			reg_rdata_ff <= 32'h0000_0000;
		end else if (i_ce) begin
			reg_rdata_ff <= 32'h0000_0000;
			if (i_reg_rd) begin
				unique case (i_reg_addr)
					mcafr_pkg::ABORT_STATUS_OFS: begin
						reg_rdata_ff[mcafr_pkg::UNDEF_FLAG_BIT] <= undef_ff;
						reg_rdata_ff[mcafr_pkg::MISALIGN_FLAG_BIT] <= misalign_ff;
						reg_rdata_ff[mcafr_pkg::ABORT_SIZE_LSB +: 2] <= abort_size_ff;
						reg_rdata_ff[mcafr_pkg::ABORT_TYPE_LSB +: 2] <= abort_type_ff;
						reg_rdata_ff[mcafr_pkg::LAST_SRC_LSB +: 3] <= last_src_ff;
						reg_rdata_ff[mcafr_pkg::SAVED_SRC_LSB +: 3] <= saved_src_ff;
					end
					mcafr_pkg::ABORT_ADDRESS_OFS: begin
						reg_rdata_ff <= abort_addr_ff;
					end
					mcafr_pkg::FLASH_MODE_OFS: begin
						reg_rdata_ff[mcafr_pkg::FWS_LSB +: 2] <= fws_ff;
					end
					mcafr_pkg::LOCK_BITS_OFS: begin
						reg_rdata_ff[LOCK_BITS-1:0] <= lock_ff;
					end
					mcafr_pkg::NVM_BITS_OFS: begin
						reg_rdata_ff[NVM_BITS:0] <= nvm_ff;
					end
					default: begin
						reg_rdata_ff <= 32'h0000_0000;
					end
				endcase
			end
		end
	end

	// ***************************************************
	// page buffer
	// ***************************************************
	// only word writes land; narrower writes would corrupt a word
	always_ff @(posedge i_sys_clk) begin
		if (take && !abort_now && i_acc_flash && (i_acc_type == mcafr_pkg::TYPE_DATA_WRITE) &&
			(i_acc_size == mcafr_pkg::SIZE_WORD)) begin
			pbuf_mem[i_acc_addr[PAGE_AW+1:2]] <= i_acc_wdata;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			pbuf_data_ff <= 32'h0000_0000;
		end else if (i_ce) begin
			pbuf_data_ff <= pbuf_mem[i_pbuf_idx];
		end
	end

	// ***************************************************
	// access sequencer
	// ***************************************************
	// aborts, writes and buffer hits finish in one cycle
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			state_ff <= mcafr_pkg::ST_IDLE;
			acc_done_ff <= 1'b0;
			acc_rdata_ff <= 32'h0000_0000;
			abort_ff <= 1'b0;
			cnt_ff <= 2'h0;
			ld_buf_ff <= 1'b0;
			fl_addr_ff <= '0;
			buf_tag_ff <= '0;
			buf_data_ff <= 32'h0000_0000;
			buf_vld_ff <= 1'b0;
			pf_tag_ff <= '0;
			pf_pend_ff <= 1'b0;
		end else if (i_ce) begin
			acc_done_ff <= 1'b0;
			abort_ff <= 1'b0;
			unique case (state_ff)
				mcafr_pkg::ST_IDLE: begin
					if (abort_now) begin
						abort_ff <= 1'b1;
						acc_done_ff <= 1'b1;
						acc_rdata_ff <= 32'h0000_0000;
					end else if (take && i_acc_flash && (i_acc_type != mcafr_pkg::TYPE_DATA_WRITE)) begin
						if (is_fetch && buf_hit) begin
							// second half of a word: start the next word now
							acc_done_ff <= 1'b1;
							acc_rdata_ff <= buf_data_ff;
							if (!pf_pend_ff) begin
								fl_addr_ff <= word_idx + 1'b1;
								pf_tag_ff <= word_idx + 1'b1;
								pf_pend_ff <= 1'b1;
							end
						end else begin
							// data reads leave the fetch buffer alone but drop a pending prefetch
							fl_addr_ff <= word_idx;
							ld_buf_ff <= is_fetch;
							pf_pend_ff <= 1'b0;
							if (cost == 2'h1) begin
								acc_done_ff <= 1'b1;
								acc_rdata_ff <= i_fl_rdata;
								if (is_fetch) begin
									buf_tag_ff <= word_idx;
									buf_data_ff <= i_fl_rdata;
									buf_vld_ff <= 1'b1;
								end
							end else begin
								cnt_ff <= cost - 2'h1;
								state_ff <= mcafr_pkg::ST_WAIT;
							end
						end
					end else if (take) begin
						acc_done_ff <= 1'b1;
						acc_rdata_ff <= 32'h0000_0000;
					end
				end
				mcafr_pkg::ST_WAIT: begin
					// array output is sampled on the last wait cycle
					if (cnt_ff == 2'h1) begin
						acc_done_ff <= 1'b1;
						acc_rdata_ff <= i_fl_rdata;
						state_ff <= mcafr_pkg::ST_IDLE;
						if (ld_buf_ff) begin
							buf_tag_ff <= fl_addr_ff;
							buf_data_ff <= i_fl_rdata;
							buf_vld_ff <= 1'b1;
						end
					end else begin
						cnt_ff <= cnt_ff - 2'h1;
					end
				end
			endcase
		end
	end

	// ***************************************************
	// outputs
	// ***************************************************
	assign o_reg_rdata = reg_rdata_ff;
	assign o_acc_done = acc_done_ff;
	assign o_acc_rdata = acc_rdata_ff;
	assign o_abort = abort_ff;
	assign o_remap = remap_ff;
	// zero wait states leave no cycle to register the address first
	assign o_fl_addr = rd_take ? word_idx : fl_addr_ff;
	assign o_pbuf_data = pbuf_data_ff;
	assign o_lock = lock_ff;
	assign o_nvm = nvm_ff;

endmodule

`default_nettype wire

// *** tb/mcafr_chk.sv ***
`timescale 1ns/1ns
`default_nettype none
module mcafr_chk (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic [7:0] i_reg_addr,
	input wire logic [31:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic [31:0] i_acc_addr,
	input wire logic i_acc_valid,
	input wire logic [1:0] i_acc_size,
	input wire logic [1:0] i_acc_type,
	input wire logic [1:0] i_acc_master,
	input wire logic i_acc_undef,
	input wire logic i_acc_flash,
	input wire logic o_acc_done,
	input wire logic [31:0] o_acc_rdata,
	input wire logic o_abort,
	input wire logic o_remap
);
	// ***********************************
	// helpers
	// ***********************************
	logic [1:0] fws_ff;
	logic mis;
	logic rmw;
	// shadow of the wait-state field: latency depends on it
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			fws_ff <= mcafr_pkg::FWS_RST;
		end else if (i_ce && i_reg_wr && i_reg_addr == mcafr_pkg::FLASH_MODE_OFS) begin
			fws_ff <= i_reg_wdata[9:8];
		end
	end
	// misalignment, processor fetches exempt
	assign mis = ((i_acc_size == 2'h2 && i_acc_addr[1:0] != 2'h0) || (i_acc_size == 2'h1 && i_acc_addr[0]))
		&& !(i_acc_type == 2'h2 && i_acc_master == 2'h2);
	assign rmw = i_ce && i_reg_wr && i_reg_addr == 8'h00 && i_reg_wdata[0];
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);
	// ***********************************
	// properties
	// ***********************************
	remap_toggle_a: assert property (rmw |=> o_remap != $past(o_remap)) else $error("remap not toggled");
	remap_hold_a: assert property (!rmw |=> $stable(o_remap)) else $error("remap moved");
	abort_cause_a: assert property (o_abort |-> i_acc_undef || mis) else $error("abort without cause");
	abort_taken_a: assert property (o_acc_done && (i_acc_undef || mis) |-> o_abort) else $error("abort missing");
	abort_nodata_a: assert property (o_abort |-> o_acc_done && o_acc_rdata == 32'h0) else $error("abort data");
	zero_ws_a: assert property ($rose(i_acc_valid) && fws_ff == 2'h0 |=> o_acc_done) else $error("zero ws");
	mid_ws_a: assert property ($rose(i_acc_valid) && fws_ff[1] != fws_ff[0] && i_acc_flash && i_acc_type == 2'h0
		&& !i_acc_undef && !mis |=> !o_acc_done ##1 o_acc_done) else $error("two cycle read");
	three_ws_a: assert property ($rose(i_acc_valid) && fws_ff == 2'h3 && i_acc_flash && i_acc_type == 2'h0
		&& !i_acc_undef && !mis |=> !o_acc_done [*2] ##1 o_acc_done) else $error("three cycle read");
endmodule
bind mcafr_top mcafr_chk u_chk (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_reg_addr(i_reg_addr),
	.i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_acc_addr(i_acc_addr), .i_acc_valid(i_acc_valid),
	.i_acc_size(i_acc_size), .i_acc_type(i_acc_type), .i_acc_master(i_acc_master), .i_acc_undef(i_acc_undef),
	.i_acc_flash(i_acc_flash), .o_acc_done(o_acc_done), .o_acc_rdata(o_acc_rdata), .o_abort(o_abort),
	.o_remap(o_remap));
`default_nettype wire

// *** tb/mcafr_flash_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module mcafr_flash_model #(
	parameter int AW = 16
) (
	input wire logic [AW-1:0] i_word_addr,
	output logic [31:0] o_word
);
	// ***********************************
	// flash array stand-in
	// ***********************************
	// both halves carry the address, so a shifted or unwrapped address shows
	assign o_word = {~i_word_addr[15:0], i_word_addr[15:0]};
endmodule
`default_nettype wire

// *** tb/memory_ctrl_abort_flash_read_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module memory_ctrl_abort_flash_read_tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] r_addr = 8'h00;
	logic [31:0] r_wdata = 32'h0;
	logic r_wr = 1'b0;
	logic r_rd = 1'b0;
	logic a_valid = 1'b0;
	logic [31:0] a_addr = 32'h0;
	logic [31:0] a_wdata = 32'h0;
	logic [1:0] a_size = 2'h0;
	logic [1:0] a_type = 2'h0;
	logic [1:0] a_mst = 2'h0;
	logic a_undef = 1'b0;
	logic a_flash = 1'b0;
	logic ce = 1'b1;
	logic [15:0] lk;
	logic [3:0] nv;
	logic [5:0] pb_idx = 6'h0;
	logic done, abort, remap;
	logic [31:0] r_rdata, a_rdata, fl_rdata, pb_data, d, a, pb_d;
	logic [15:0] fl_addr;
	logic [5:0] pb_i;
	logic [2:0] last_src = 3'h0;
	logic [2:0] saved = 3'h0;
	logic [18:0] st = 19'h0;
	logic [31:0] ea = 32'h0;
	logic unread = 1'b0;
	logic rmp = 1'b0;
	logic un;
	logic [1:0] flash_wait_states = 2'h0;
	logic [1:0] tp;
	int num_errors = 0;
	int compares = 0;
	int cycles = 0;
	int i, k, f, n;

	always #25 clk = ~clk;

	mcafr_top u_dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_reg_addr(r_addr), .i_reg_wdata(r_wdata),
		.i_reg_wr(r_wr), .i_reg_rd(r_rd), .o_reg_rdata(r_rdata), .i_acc_valid(a_valid), .i_acc_addr(a_addr),
		.i_acc_size(a_size), .i_acc_type(a_type), .i_acc_master(a_mst), .i_acc_wdata(a_wdata),
		.i_acc_undef(a_undef), .i_acc_flash(a_flash), .o_acc_done(done), .o_acc_rdata(a_rdata), .o_abort(abort),
		.o_remap(remap), .o_fl_addr(fl_addr), .i_fl_rdata(fl_rdata), .i_pbuf_idx(pb_idx), .o_pbuf_data(pb_data),
		.o_lock(lk), .o_nvm(nv));
	mcafr_flash_model u_fl (.i_word_addr(fl_addr), .o_word(fl_rdata));

	// ***********************************
	// checking and bus tasks
	// ***********************************
	task automatic print_verdict();
		if (num_errors == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	function automatic logic [31:0] fl(input logic [31:0] x);
		return {~x[17:2], x[17:2]};
	endfunction
	function automatic logic [31:0] cost();
		return flash_wait_states == 2'h0 ? 32'h1 : flash_wait_states == 2'h1 ? 32'h2 : 32'(flash_wait_states);
	endfunction
	task automatic reg_wr(input logic [7:0] ad, input logic [31:0] dt);
		@(posedge clk);
		r_addr <= ad;
		r_wdata <= dt;
		r_wr <= 1'b1;
		@(posedge clk);
		r_wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic reg_rd(input logic [7:0] ad, output logic [31:0] dt);
		@(posedge clk);
		r_addr <= ad;
		r_rd <= 1'b1;
		@(posedge clk);
		r_rd <= 1'b0;
		#1;
		dt = r_rdata;
	endtask
	// a status read clears the saved-source bits
	task automatic rd_stat();
		reg_rd(mcafr_pkg::ABORT_STATUS_OFS, d);
		chk("status", {5'h0, saved, 5'h0, st}, d);
		saved = 3'h0;
		unread = 1'b0;
		reg_rd(mcafr_pkg::ABORT_ADDRESS_OFS, d);
		chk("abort address", ea, d);
	endtask
	task automatic set_fws(input logic [1:0] w);
		reg_wr(mcafr_pkg::FLASH_MODE_OFS, 32'(w) << mcafr_pkg::FWS_LSB);
		flash_wait_states = w;
	endtask
	// request held until done; dropped the cycle after
	task automatic acc(input logic [31:0] ad, input logic [1:0] sz, input logic [1:0] ty, input logic [1:0] ms,
		input logic u, output int c);
		logic [31:0] wd;
		logic mis;
		wd = $urandom;
		mis = ((sz == 2'h2 && ad[1:0] != 2'h0) || (sz == 2'h1 && ad[0])) && !(ty == 2'h2 && ms == 2'h2);
		@(posedge clk);
		a_valid <= 1'b1;
		a_addr <= ad;
		a_size <= sz;
		a_type <= ty;
		a_mst <= ms;
		a_undef <= u;
		a_flash <= !u;
		a_wdata <= wd;
		c = 0;
		do begin
			@(posedge clk);
			#1;
			c++;
		end while (done !== 1'b1 && c < 20);
		chk("done", 32'h1, {31'h0, done});
		chk("abort", 32'(u | mis), 32'(abort));
		if (u | mis) begin
			if (unread) saved = saved | last_src;
			last_src = 3'h1 << ms;
			unread = 1'b1;
			st = {last_src, 4'h0, ty, sz, 6'h0, mis, u};
			ea = ad;
		end else if (ty == 2'h1) begin
			pb_i = ad[7:2];
			pb_d = wd;
		end else begin
			chk("read data", fl(ad), a_rdata);
		end
		if (ty != 2'h2) chk("cost", (u | mis | ty[0]) ? 32'h1 : cost(), 32'(c));
		@(posedge clk);
		a_valid <= 1'b0;
	endtask

	// ***********************************
	// watchdog and main sequence
	// ***********************************
	// a hang ends the run as a failure
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			print_verdict();
		end
	end
	initial begin
		void'($urandom(28174));
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		rd_stat();
		reg_rd(8'h40, d);
		chk("unmapped", 32'h0, d);
		for (i = 0; i < 4; i++) begin
			reg_wr(mcafr_pkg::REMAP_CONTROL_OFS, {31'h2aaa_aaaa, i == 1 || i == 2});
			rmp = rmp ^ (i == 1 || i == 2);
			#1;
			chk("remap", 32'(rmp), 32'(remap));
		end
		// a frozen block ignores a remap write
		@(posedge clk);
		ce <= 1'b0;
		reg_wr(mcafr_pkg::REMAP_CONTROL_OFS, 32'h0000_0001);
		#1;
		chk("frozen remap", 32'(rmp), 32'(remap));
		@(posedge clk);
		ce <= 1'b1;
		a = $urandom;
		reg_wr(mcafr_pkg::LOCK_BITS_OFS, a);
		reg_wr(mcafr_pkg::NVM_BITS_OFS, ~a);
		#1;
		chk("lock bits", {16'h0, a[15:0]}, {16'h0, lk});
		chk("nvm bits", {28'h0, ~a[3:0]}, {28'h0, nv});
		reg_rd(mcafr_pkg::LOCK_BITS_OFS, d);
		chk("lock readback", {16'h0, a[15:0]}, d);
		// half-word fetch runs: second half hits, next word is prefetched
		for (f = 0; f < 4; f++) begin
			set_fws(f[1:0]);
			for (k = 0; k < 4; k++) begin
				acc(32'h0014_0100 + 32'(2 * k), 2'h1, 2'h2, 2'h2, 1'b0, n);
				chk("fetch cost", (k % 2 == 1 || (k > 0 && f == 1)) ? 32'h1 : cost(), 32'(n));
			end
			acc(32'h0014_0108, 2'h2, 2'h0, 2'h0, 1'b0, n);
		end
		acc(32'h0014_0202, 2'h2, 2'h2, 2'h2, 1'b0, n);
		acc(32'h0014_0003, 2'h2, 2'h2, 2'h1, 1'b0, n);
		reg_wr(mcafr_pkg::ABORT_STATUS_OFS, 32'hffff_ffff);
		rd_stat();
		// one aligned word write so the page buffer check always has a target
		acc(32'h0010_0040, 2'h2, 2'h1, 2'h1, 1'b0, n);
		for (i = 0; i < 60; i++) begin
			if (i % 8 == 0) set_fws(2'($urandom_range(3)));
			un = $urandom_range(7) == 0;
			tp = 2'($urandom_range(1));
			a = 32'h0010_0000 | ($urandom & 32'h000f_ffff);
			if (un) a = {4'h5, a[27:2], 2'h0};
			acc(a, tp[0] ? 2'h2 : 2'($urandom_range(2)), tp, 2'($urandom_range(2)), un, n);
			if ($urandom_range(1) == 1) rd_stat();
		end
		rd_stat();
		@(posedge clk);
		pb_idx <= pb_i;
		repeat (2) @(posedge clk);
		#1;
		chk("page buffer", pb_d, pb_data);
		print_verdict();
	end
endmodule
`default_nettype wire
